// ---- rtl/sxs_alu_regs.svh ----
// Constants for the subtract / xor / swap datapath slice.
// Assumes it is included by the package, the datapath files and the bench.
`ifndef SXS_ALU_REGS_SVH
`define SXS_ALU_REGS_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SXS_DATA_W     8
`define SXS_ADDR_W     7
`define SXS_ADDR_MAX   7'h7f
`define SXS_ADDR_RST   7'h00
`define SXS_W_RST      8'h00
`define SXS_FLAG_RST   1'b0

// ----------------------------------------
// Destination select encoding
// ----------------------------------------
`define SXS_DEST_W     1'b0
`define SXS_DEST_FILE  1'b1

`endif

// ---- rtl/sxs_alu_pkg.sv ----
// Types for the subtract / xor / swap datapath slice.
// Assumes the constant header is on the include path.
`include "sxs_alu_regs.svh"
package sxs_alu_pkg;

  // ----------------------------------------
  // Operation select, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    SXS_OP_SUBTRACT_W_FROM_FILE = 4'h1,
    SXS_OP_XOR_W_WITH_FILE      = 4'h2,
    SXS_OP_SWAP_FILE_NIBBLES    = 4'h4,
    SXS_OP_XOR_LITERAL_WITH_W   = 4'h8
  } sxs_op_t;

  typedef logic [`SXS_DATA_W-1:0] sxs_byte_t;
  typedef logic [`SXS_ADDR_W-1:0] sxs_addr_t;

endpackage

// ---- rtl/sxs_alu_core.sv ----
// Combinational result and flag generation for the four operations.
// Assumes operands are stable in the cycle the operation is issued.
`timescale 1ns/1ps
`include "sxs_alu_regs.svh"
module sxs_alu_core (
  // Operation and operands
  input  wire sxs_alu_pkg::sxs_op_t   op,
  input  wire sxs_alu_pkg::sxs_byte_t w_val,
  input  wire sxs_alu_pkg::sxs_byte_t file_val,
  input  wire sxs_alu_pkg::sxs_byte_t literal,
  // Result and flags
  output      sxs_alu_pkg::sxs_byte_t result,
  output logic                         carry,
  output logic                         digit_carry,
  output logic                         zero,
  output logic                         upd_c_dc,
  output logic                         upd_zero
);
  import sxs_alu_pkg::*;

  logic [`SXS_DATA_W:0] diff;
  logic [4:0]           ldiff;

  always_comb begin
    diff        = {1'b0, file_val} - {1'b0, w_val};
    ldiff       = {1'b0, file_val[3:0]} - {1'b0, w_val[3:0]};
    result      = `SXS_W_RST;
    carry       = ~diff[`SXS_DATA_W];
    digit_carry = ~ldiff[4];
    upd_c_dc    = 1'b0;
    upd_zero    = 1'b0;
    case (op)
      SXS_OP_SUBTRACT_W_FROM_FILE: begin
        result   = diff[`SXS_DATA_W-1:0];
        upd_c_dc = 1'b1;
        upd_zero = 1'b1;
      end
      SXS_OP_XOR_W_WITH_FILE: begin
        result   = w_val ^ file_val;
        upd_zero = 1'b1;
      end
      SXS_OP_SWAP_FILE_NIBBLES: begin
        result = {file_val[3:0], file_val[7:4]};
      end
      SXS_OP_XOR_LITERAL_WITH_W: begin
        result   = w_val ^ literal;
        upd_zero = 1'b1;
      end
      default: begin
        result = `SXS_W_RST;
      end
    endcase
    zero = (result == `SXS_W_RST);
  end

endmodule

// ---- rtl/sxs_alu.sv ----
// Datapath slice: holds the working register and status flags, and
// issues file write-backs. Assumes the decoder pulses op_valid for one
// cycle per instruction and supplies the addressed file value in that cycle.
// Also assumes the register file applies file_we, file_waddr and file_wdata
// on the edge after they appear, and forwards a fresh value itself if needed.
`timescale 1ns/1ps
`include "sxs_alu_regs.svh"
module sxs_alu (
  // Clock and reset
  input  wire  logic                   sys_clk,
  input  wire  logic                   rst_n,
  // Instruction issue
  input  wire  logic                   op_valid,
  input  wire  sxs_alu_pkg::sxs_op_t   op,
  input  wire  logic                   dest_sel,
  input  wire  sxs_alu_pkg::sxs_addr_t file_addr,
  input  wire  sxs_alu_pkg::sxs_byte_t file_rdata,
  input  wire  sxs_alu_pkg::sxs_byte_t literal,
  // File write-back
  output logic                         file_we,
  output sxs_alu_pkg::sxs_addr_t       file_waddr,
  output sxs_alu_pkg::sxs_byte_t       file_wdata,
  // Architectural state
  output sxs_alu_pkg::sxs_byte_t       w_reg,
  output logic                         carry_flag,
  output logic                         digit_carry_flag,
  output logic                         zero_flag
);
  import sxs_alu_pkg::*;

  // ----------------------------------------
  // Operation evaluation
  // ----------------------------------------
  sxs_byte_t res;
  logic      c_n, dc_n, z_n, upd_cd, upd_z;

  sxs_alu_core u_core (
    .op          (op),
    .w_val       (w_reg),
    .file_val    (file_rdata),
    .literal     (literal),
    .result      (res),
    .carry       (c_n),
    .digit_carry (dc_n),
    .zero        (z_n),
    .upd_c_dc    (upd_cd),
    .upd_zero    (upd_z)
  );

  // ----------------------------------------
  // Flag update enables
  // ----------------------------------------
  // The core decodes the operation code on its own; gating its masks with
  // op_valid keeps a code left standing between issues from moving a flag
  logic upd_cd_en, upd_z_en;

  always_comb begin
    upd_cd_en = op_valid && upd_cd;
    upd_z_en  = op_valid && upd_z;
  end

  // ----------------------------------------
  // Destination routing
  // ----------------------------------------
  // The literal form has no file operand, so it always targets the working
  // register and dest_sel is a don't-care for it
  logic is_literal, to_w, to_file;

  always_comb begin
    is_literal = (op == SXS_OP_XOR_LITERAL_WITH_W);
    to_w       = op_valid && (is_literal || (dest_sel == `SXS_DEST_W));
    to_file    = op_valid && !is_literal && (dest_sel == `SXS_DEST_FILE);
  end

  // ----------------------------------------
  // Working register
  // ----------------------------------------
  // The core reads w_q, so an issue sees the result of the one before it
  sxs_byte_t w_d, w_q;

  always_comb begin
    w_d = w_q;
    if (to_w) begin
      w_d = res;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= `SXS_W_RST;
    end else begin
      w_q <= w_d;
    end
  end

  // ----------------------------------------
  // Carry flag
  // ----------------------------------------
  // Reads as no borrow: set when the subtraction did not wrap
  logic c_d, c_q;

  always_comb begin
    c_d = c_q;
    if (upd_cd_en) begin
      c_d = c_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= `SXS_FLAG_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------
  // Digit carry flag
  // ----------------------------------------
  // Same sense as carry, taken from the low nibbles alone
  logic dc_d, dc_q;

  always_comb begin
    dc_d = dc_q;
    if (upd_cd_en) begin
      dc_d = dc_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dc_q <= `SXS_FLAG_RST;
    end else begin
      dc_q <= dc_d;
    end
  end

  // ----------------------------------------
  // Zero flag
  // ----------------------------------------
  // Loaded only by operations that report a zero result; the nibble swap
  // leaves whatever the previous operation put here
  logic z_d, z_q;

  always_comb begin
    z_d = z_q;
    if (upd_z_en) begin
      z_d = z_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      z_q <= `SXS_FLAG_RST;
    end else begin
      z_q <= z_d;
    end
  end

  // ----------------------------------------
  // File write strobe
  // ----------------------------------------
  // One-cycle pulse per file-bound issue, low in every other cycle
  logic we_d, we_q;

  always_comb begin
    we_d = to_file;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'b0;
    end else begin
      we_q <= we_d;
    end
  end

  // ----------------------------------------
  // File write address
  // ----------------------------------------
  // Address and data hold after the strobe drops, so a register file that
  // samples them late still sees the pair that went with the strobe
  sxs_addr_t waddr_d, waddr_q;

  always_comb begin
    waddr_d = waddr_q;
    if (to_file) begin
      waddr_d = file_addr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waddr_q <= `SXS_ADDR_RST;
    end else begin
      waddr_q <= waddr_d;
    end
  end

  // ----------------------------------------
  // File write data
  // ----------------------------------------
  sxs_byte_t wdata_d, wdata_q;

  always_comb begin
    wdata_d = wdata_q;
    if (to_file) begin
      wdata_d = res;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= `SXS_W_RST;
    end else begin
      wdata_q <= wdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a register, so the register file never sees core glitches
  assign w_reg            = w_q;
  assign carry_flag       = c_q;
  assign digit_carry_flag = dc_q;
  assign zero_flag        = z_q;
  assign file_we          = we_q;
  assign file_waddr       = waddr_q;
  assign file_wdata       = wdata_q;

endmodule

// ---- verif/sxs_alu_checker.sv ----
// Port checker for the datapath slice.
// Assumes bind to sxs_alu; one clock, async active-low reset.
`timescale 1ns/1ps
module sxs_alu_checker (
  // Clock and issue
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   op_valid,
  input wire sxs_alu_pkg::sxs_op_t   op,
  input wire logic                   dest_sel,
  input wire sxs_alu_pkg::sxs_addr_t file_addr,
  input wire sxs_alu_pkg::sxs_byte_t file_rdata,
  input wire sxs_alu_pkg::sxs_byte_t literal,
  // Results
  input wire logic                   file_we,
  input wire sxs_alu_pkg::sxs_addr_t file_waddr,
  input wire sxs_alu_pkg::sxs_byte_t file_wdata,
  input wire sxs_alu_pkg::sxs_byte_t w_reg,
  input wire logic                   carry_flag,
  input wire logic                   digit_carry_flag,
  input wire logic                   zero_flag
);
  import sxs_alu_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_sub_carry: assert property (op_valid && op == SXS_OP_SUBTRACT_W_FROM_FILE |=>
    carry_flag == ($past(w_reg) <= $past(file_rdata))) else $error("carry wrong");
  chk_sub_digit: assert property (op_valid && op == SXS_OP_SUBTRACT_W_FROM_FILE |=>
    digit_carry_flag == ($past(w_reg[3:0]) <= $past(file_rdata[3:0]))) else $error("digit carry wrong");
  chk_sub_result: assert property (op_valid && op == SXS_OP_SUBTRACT_W_FROM_FILE && !dest_sel |=>
    w_reg == sxs_byte_t'($past(file_rdata) - $past(w_reg))) else $error("difference wrong");
  chk_dest_file: assert property (op_valid && dest_sel && op != SXS_OP_XOR_LITERAL_WITH_W |=>
    file_we && file_waddr == $past(file_addr) && $stable(w_reg)) else $error("write-back wrong");
  chk_swap_flags: assert property (op_valid && op == SXS_OP_SWAP_FILE_NIBBLES |=>
    $stable({carry_flag, digit_carry_flag, zero_flag})) else $error("swap touched flags");
  chk_swap_result: assert property (op_valid && op == SXS_OP_SWAP_FILE_NIBBLES && !dest_sel |=>
    w_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap result wrong");
  chk_xor_cflags: assert property (op_valid && op inside {SXS_OP_XOR_W_WITH_FILE, SXS_OP_XOR_LITERAL_WITH_W} |=>
    $stable(carry_flag) && $stable(digit_carry_flag)) else $error("xor touched carry");
  chk_lit_zero: assert property (op_valid && op == SXS_OP_XOR_LITERAL_WITH_W |=>
    !file_we && w_reg == ($past(w_reg) ^ $past(literal)) && zero_flag == (w_reg == 8'h00)) else $error("literal xor wrong");
  chk_xorf_file: assert property (op_valid && op == SXS_OP_XOR_W_WITH_FILE && dest_sel |=>
    file_wdata == ($past(w_reg) ^ $past(file_rdata)) && zero_flag == (file_wdata == 8'h00)) else $error("file xor wrong");
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the datapath slice.
// Assumes the bench also plays decoder and register file.
`timescale 1ns/1ps
`include "sxs_alu_regs.svh"
module tb_top;
  import sxs_alu_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, dest_sel = 1'b0, v_q = 1'b0;
  sxs_op_t     op = SXS_OP_SWAP_FILE_NIBBLES;
  sxs_addr_t   file_addr = 7'h00, file_waddr, ma = 7'h00;
  sxs_byte_t   file_rdata = 8'h00, literal = 8'h00, file_wdata, w_reg, md = 8'h00, mw = 8'h00;
  logic        file_we, carry_flag, digit_carry_flag, zero_flag, mwe, mc = 1'b0, mdc = 1'b0, mz = 1'b0;
  logic [26:0] exp_q[$];
  int          err_count = 0, n_checks = 0;
  sxs_op_t     ops[4] = '{SXS_OP_SUBTRACT_W_FROM_FILE, SXS_OP_XOR_W_WITH_FILE,
                          SXS_OP_SWAP_FILE_NIBBLES, SXS_OP_XOR_LITERAL_WITH_W};
  always #25 sys_clk = ~sys_clk;
  sxs_alu dut_u (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .op_valid         (op_valid),
    .op               (op),
    .dest_sel         (dest_sel),
    .file_addr        (file_addr),
    .file_rdata       (file_rdata),
    .literal          (literal),
    .file_we          (file_we),
    .file_waddr       (file_waddr),
    .file_wdata       (file_wdata),
    .w_reg            (w_reg),
    .carry_flag       (carry_flag),
    .digit_carry_flag (digit_carry_flag),
    .zero_flag        (zero_flag)
  );
  localparam logic [26:0] rst_obs = {1'b0, `SXS_ADDR_RST, `SXS_W_RST, `SXS_W_RST,
                                     `SXS_FLAG_RST, `SXS_FLAG_RST, `SXS_FLAG_RST};
  logic [26:0] obs;
  assign obs = {file_we, file_waddr, file_wdata, w_reg, carry_flag, digit_carry_flag, zero_flag};
  task check(input logic [26:0] seen, input logic [26:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("mismatch at %0t: %h vs %h", $time, seen, expv);
    end
  endtask
  task print_verdict;
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Issue one operation and note what the ports must show after it
  task issue(input sxs_op_t o, input logic d, input sxs_addr_t a, input sxs_byte_t f, input sxs_byte_t k);
    sxs_byte_t r;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op <= o;
    dest_sel <= d;
    file_addr <= a;
    file_rdata <= f;
    literal <= k;
    case (o)
      SXS_OP_SUBTRACT_W_FROM_FILE: begin
        r = f - mw;
        mc = mw <= f;
        mdc = mw[3:0] <= f[3:0];
      end
      SXS_OP_XOR_W_WITH_FILE: r = mw ^ f;
      SXS_OP_SWAP_FILE_NIBBLES: r = {f[3:0], f[7:4]};
      default: r = mw ^ k;
    endcase
    if (o != SXS_OP_SWAP_FILE_NIBBLES) mz = r == 8'h00;
    mwe = d && o != SXS_OP_XOR_LITERAL_WITH_W;
    if (mwe) {ma, md} = {a, r};
    else mw = r;
    exp_q.push_back({mwe, ma, md, mw, mc, mdc, mz});
  endtask
  always @(posedge sys_clk) v_q <= op_valid;
  always @(negedge sys_clk) begin
    if (v_q && exp_q.size() > 0)
      check(obs, exp_q.pop_front());
  end
  initial begin
    sxs_byte_t f;
    void'($urandom(44624));
    repeat (19) @(posedge sys_clk);
    @(negedge sys_clk);
    check(obs, rst_obs);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 600; i++) begin
      // Equal operands give zero results and the carry boundary
      f = (i % 5 == 0) ? mw : 8'($urandom);
      issue(ops[$urandom % 4], 1'($urandom), 7'($urandom), f, (i % 3 == 0) ? mw : 8'($urandom));
      if (i % 7 == 3) begin
        @(posedge sys_clk);
        op_valid <= 1'b0;
      end
      // Mid-run reset: ports and model both fall back to reset values
      if (i == 300) begin
        @(posedge sys_clk);
        op_valid <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(negedge sys_clk);
        check(obs, rst_obs);
        {ma, md, mw, mc, mdc, mz} = rst_obs[25:0];
        @(posedge sys_clk);
        rst_n <= 1'b1;
      end
    end
    @(posedge sys_clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(27'(exp_q.size()), 27'h0);
    print_verdict;
  end
  initial begin
    #200000;
    err_count++;
    print_verdict;
  end
endmodule
bind sxs_alu sxs_alu_checker chk_u (
  .sys_clk          (sys_clk),
  .rst_n            (rst_n),
  .op_valid         (op_valid),
  .op               (op),
  .dest_sel         (dest_sel),
  .file_addr        (file_addr),
  .file_rdata       (file_rdata),
  .literal          (literal),
  .file_we          (file_we),
  .file_waddr       (file_waddr),
  .file_wdata       (file_wdata),
  .w_reg            (w_reg),
  .carry_flag       (carry_flag),
  .digit_carry_flag (digit_carry_flag),
  .zero_flag        (zero_flag)
);
